// [rtl/uiifc_pkg.sv]
// Package with the offsets, field layouts, reset values and codes of the interrupt-id and FIFO-control block.
package uiifc_pkg;
	localparam int unsigned ADDR_W = 3;
	localparam logic [ADDR_W-1:0] OFF_BAUD_DIVISOR_HIGH = 3'h1;
	localparam logic [ADDR_W-1:0] OFF_INTERRUPT_SOURCE_ID = 3'h2;
	localparam logic [ADDR_W-1:0] OFF_FIFO_CONTROL = 3'h2;
	localparam logic [7:0] RST_BAUD_DIVISOR_HIGH = 8'h00;
	localparam logic [7:0] RST_INTERRUPT_SOURCE_ID = 8'h01;
	localparam logic [7:0] RST_FIFO_CONTROL = 8'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	localparam int unsigned LC_DIVISOR_ENABLE_BIT = 7;
	localparam logic [7:0] LC_ENHANCED_ACCESS = 8'hBF;
	localparam int unsigned EFC_ENHANCED_ENABLE_BIT = 4;
	localparam int unsigned FC_FIFO_ENABLE_BIT = 0;
	localparam int unsigned FC_TX_RESET_BIT = 2;
	localparam int unsigned FC_TX_TRIG_LSB = 4;
	localparam int unsigned FC_RX_TRIG_LSB = 6;
	localparam int unsigned ID_NONE_BIT = 0;
	localparam logic [5:0] ID_NONE = 6'h01;
	localparam logic [5:0] ID_LINE_STATUS = 6'h06;
	localparam logic [5:0] ID_RX_TIMEOUT = 6'h0C;
	localparam logic [5:0] ID_RX_DATA = 6'h04;
	localparam logic [5:0] ID_TX_EMPTY = 6'h02;
	localparam logic [5:0] ID_MODEM = 6'h00;
	localparam logic [5:0] ID_GPIO_CHANGE = 6'h30;
	localparam logic [5:0] ID_XOFF_SPECIAL = 6'h10;
	localparam logic [5:0] ID_FLOW_INACTIVE = 6'h20;
	localparam int unsigned LEVEL_W = 7;
	localparam logic [LEVEL_W-1:0] LEVEL_SINGLE = 7'h01;
	localparam logic [LEVEL_W-1:0] RX_LEVEL_0 = 7'h08;
	localparam logic [LEVEL_W-1:0] RX_LEVEL_1 = 7'h10;
	localparam logic [LEVEL_W-1:0] RX_LEVEL_2 = 7'h38;
	localparam logic [LEVEL_W-1:0] RX_LEVEL_3 = 7'h3C;
	localparam logic [LEVEL_W-1:0] TX_LEVEL_0 = 7'h08;
	localparam logic [LEVEL_W-1:0] TX_LEVEL_1 = 7'h10;
	localparam logic [LEVEL_W-1:0] TX_LEVEL_2 = 7'h20;
	localparam logic [LEVEL_W-1:0] TX_LEVEL_3 = 7'h38;
	localparam int unsigned FIFO_DEPTH = 64;
endpackage : uiifc_pkg

// [rtl/uiifc_irq_encode.sv]
// Priority encoder from pending interrupt sources to the six-bit identification code.
`timescale 1ns/10ps
module uiifc_irq_encode
	import uiifc_pkg::*;
(
	input wire logic i_src_line_status,
	input wire logic i_src_rx_timeout,
	input wire logic i_src_rx_data,
	input wire logic i_src_tx_empty,
	input wire logic i_src_modem,
	input wire logic i_src_gpio_change,
	input wire logic i_src_xoff_special,
	input wire logic i_src_flow_inactive,
	output logic [5:0] o_id
);
	// The first pending source in this chain wins; later ones stay hidden until it clears.
	always_comb begin
		if (i_src_line_status) begin
			o_id = ID_LINE_STATUS;
		end else if (i_src_rx_timeout) begin
			o_id = ID_RX_TIMEOUT;
		end else if (i_src_rx_data) begin
			o_id = ID_RX_DATA;
		end else if (i_src_tx_empty) begin
			o_id = ID_TX_EMPTY;
		end else if (i_src_modem) begin
			o_id = ID_MODEM;
		end else if (i_src_gpio_change) begin
			o_id = ID_GPIO_CHANGE;
		end else if (i_src_xoff_special) begin
			o_id = ID_XOFF_SPECIAL;
		end else if (i_src_flow_inactive) begin
			o_id = ID_FLOW_INACTIVE;
		end else begin
			o_id = ID_NONE;
		end
	end
endmodule : uiifc_irq_encode

// [rtl/uiifc_trig_decode.sv]
// Decoder from the FIFO-control trigger fields to trigger levels in characters or spaces.
`timescale 1ns/10ps
module uiifc_trig_decode
	import uiifc_pkg::*;
(
	input wire logic i_fifo_enable,
	input wire logic [1:0] i_rx_sel,
	input wire logic [1:0] i_tx_sel,
	output logic [LEVEL_W-1:0] o_rx_level,
	output logic [LEVEL_W-1:0] o_tx_level
);
	function automatic logic [LEVEL_W-1:0] pick(input logic [1:0] sel, input logic [LEVEL_W-1:0] l0,
			input logic [LEVEL_W-1:0] l1, input logic [LEVEL_W-1:0] l2, input logic [LEVEL_W-1:0] l3);
		unique case (sel)
			2'h0: pick = l0;
			2'h1: pick = l1;
			2'h2: pick = l2;
			2'h3: pick = l3;
		endcase
	endfunction : pick

	// Without FIFOs each side holds one character, so the trigger collapses to one.
	always_comb begin
		if (i_fifo_enable) begin
			o_rx_level = pick(i_rx_sel, RX_LEVEL_0, RX_LEVEL_1, RX_LEVEL_2, RX_LEVEL_3);
			o_tx_level = pick(i_tx_sel, TX_LEVEL_0, TX_LEVEL_1, TX_LEVEL_2, TX_LEVEL_3);
		end else begin
			o_rx_level = LEVEL_SINGLE;
			o_tx_level = LEVEL_SINGLE;
		end
	end
endmodule : uiifc_trig_decode

// [rtl/uiifc_regs.sv]
// Upper divisor byte, interrupt identification and FIFO control registers of the UART bridge.
`timescale 1ns/10ps
module uiifc_regs
	import uiifc_pkg::*;
#(
	parameter int unsigned ADDR_WIDTH = ADDR_W
)(
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_soft_reset,
	input wire logic [ADDR_WIDTH-1:0] i_reg_addr,
	input wire logic i_reg_write,
	input wire logic i_reg_read,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] i_line_control,
	input wire logic [7:0] i_enhanced_feature_ctrl,
	input wire logic i_src_line_status,
	input wire logic i_src_rx_timeout,
	input wire logic i_src_rx_data,
	input wire logic i_src_tx_empty,
	input wire logic i_src_modem,
	input wire logic i_src_gpio_change,
	input wire logic i_src_xoff_special,
	input wire logic i_src_flow_inactive,
	output logic [7:0] o_reg_rdata,
	output logic [7:0] o_baud_divisor_high,
	output logic [7:0] o_interrupt_source_id,
	output logic o_int_pending,
	output logic o_fifo_enable,
	output logic o_tx_fifo_reset,
	output logic [LEVEL_W-1:0] o_rx_trigger_level,
	output logic [LEVEL_W-1:0] o_tx_trigger_level
);
	// The offsets are fixed three-bit codes, so any other address width is refused at elaboration.
	if (ADDR_WIDTH != ADDR_W) begin : g_bad_width
		$error("uiifc_regs: ADDR_WIDTH must match the register offsets");
	end

	typedef struct packed {
		logic [7:0] divisor_high;
		logic fifo_enable;
		logic [1:0] rx_trig;
		logic [1:0] tx_trig;
		logic tx_reset;
		logic [7:0] source_id;
		logic pending;
		logic [7:0] rdata;
		logic [LEVEL_W-1:0] rx_level;
		logic [LEVEL_W-1:0] tx_level;
	} uiifc_state_t;

	uiifc_state_t state;
	uiifc_state_t next_state;
	logic [5:0] id_code;
	logic [7:0] source_id_now;
	logic [LEVEL_W-1:0] rx_level_dec;
	logic [LEVEL_W-1:0] tx_level_dec;
	logic divisor_open;
	logic normal_open;
	logic enhanced_on;

	uiifc_irq_encode u_encode (
		.i_src_line_status(i_src_line_status),
		.i_src_rx_timeout(i_src_rx_timeout),
		.i_src_rx_data(i_src_rx_data),
		.i_src_tx_empty(i_src_tx_empty),
		.i_src_modem(i_src_modem),
		.i_src_gpio_change(i_src_gpio_change),
		.i_src_xoff_special(i_src_xoff_special),
		.i_src_flow_inactive(i_src_flow_inactive),
		.o_id(id_code)
	);

	// Levels follow the stored fields, so they settle one cycle after the field itself.
	uiifc_trig_decode u_trig (
		.i_fifo_enable(state.fifo_enable),
		.i_rx_sel(state.rx_trig),
		.i_tx_sel(state.tx_trig),
		.o_rx_level(rx_level_dec),
		.o_tx_level(tx_level_dec)
	);

	always_comb begin
		divisor_open = i_line_control[LC_DIVISOR_ENABLE_BIT] && (i_line_control != LC_ENHANCED_ACCESS);
		normal_open = !i_line_control[LC_DIVISOR_ENABLE_BIT];
		enhanced_on = i_enhanced_feature_ctrl[EFC_ENHANCED_ENABLE_BIT];
		source_id_now = {state.fifo_enable, state.fifo_enable, id_code};
	end

	always_comb begin
		next_state = state;
		next_state.tx_reset = 1'b0;
		next_state.source_id = source_id_now;
		// The pending flag gets its own flop so the output carries no gate after the register.
		next_state.pending = !source_id_now[ID_NONE_BIT];
		next_state.rx_level = rx_level_dec;
		next_state.tx_level = tx_level_dec;
		if (i_reg_read) begin
			if (divisor_open && i_reg_addr == OFF_BAUD_DIVISOR_HIGH) begin
				next_state.rdata = state.divisor_high;
			end else if (normal_open && i_reg_addr == OFF_INTERRUPT_SOURCE_ID) begin
				next_state.rdata = source_id_now;
			end else begin
				next_state.rdata = READ_UNMAPPED;
			end
		end
		if (i_reg_write && divisor_open && i_reg_addr == OFF_BAUD_DIVISOR_HIGH) begin
			next_state.divisor_high = i_reg_wdata;
		end
		if (i_reg_write && normal_open && i_reg_addr == OFF_FIFO_CONTROL) begin
			next_state.fifo_enable = i_reg_wdata[FC_FIFO_ENABLE_BIT];
			next_state.tx_reset = i_reg_wdata[FC_TX_RESET_BIT];
			// Trigger fields are not programmable while the FIFOs are being switched off.
			if (i_reg_wdata[FC_FIFO_ENABLE_BIT]) begin
				next_state.rx_trig = i_reg_wdata[FC_RX_TRIG_LSB +: 2];
				if (enhanced_on) begin
					next_state.tx_trig = i_reg_wdata[FC_TX_TRIG_LSB +: 2];
				end
			end
		end
		// Software reset returns control to defaults but keeps the baud rate running.
		if (i_soft_reset) begin
			next_state.fifo_enable = RST_FIFO_CONTROL[FC_FIFO_ENABLE_BIT];
			next_state.rx_trig = RST_FIFO_CONTROL[FC_RX_TRIG_LSB +: 2];
			next_state.tx_trig = RST_FIFO_CONTROL[FC_TX_TRIG_LSB +: 2];
			next_state.tx_reset = 1'b0;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			state.divisor_high <= RST_BAUD_DIVISOR_HIGH;
			state.fifo_enable <= RST_FIFO_CONTROL[FC_FIFO_ENABLE_BIT];
			state.rx_trig <= RST_FIFO_CONTROL[FC_RX_TRIG_LSB +: 2];
			state.tx_trig <= RST_FIFO_CONTROL[FC_TX_TRIG_LSB +: 2];
			state.tx_reset <= 1'b0;
			state.source_id <= RST_INTERRUPT_SOURCE_ID;
			state.pending <= 1'b0;
			state.rdata <= READ_UNMAPPED;
			state.rx_level <= LEVEL_SINGLE;
			state.tx_level <= LEVEL_SINGLE;
		end else begin
			state <= next_state;
		end
	end

	always_comb begin
		o_reg_rdata = state.rdata;
		o_baud_divisor_high = state.divisor_high;
		o_interrupt_source_id = state.source_id;
		o_int_pending = state.pending;
		o_fifo_enable = state.fifo_enable;
		o_tx_fifo_reset = state.tx_reset;
		o_rx_trigger_level = state.rx_level;
		o_tx_trigger_level = state.tx_level;
	end

	logic div_wr;
	logic fc_wr;
	logic id_rd;
	logic div_rd;
	logic [7:0] src_vec;
	always_comb begin
		div_wr = i_reg_write && divisor_open && i_reg_addr == OFF_BAUD_DIVISOR_HIGH;
		fc_wr = i_reg_write && normal_open && i_reg_addr == OFF_FIFO_CONTROL && !i_soft_reset;
		id_rd = i_reg_read && normal_open && i_reg_addr == OFF_INTERRUPT_SOURCE_ID;
		div_rd = i_reg_read && divisor_open && i_reg_addr == OFF_BAUD_DIVISOR_HIGH;
		src_vec = {i_src_line_status, i_src_rx_timeout, i_src_rx_data, i_src_tx_empty, i_src_modem,
			i_src_gpio_change, i_src_xoff_special, i_src_flow_inactive};
	end

	sequence s_txreset_pulse;
		o_tx_fifo_reset ##1 !o_tx_fifo_reset;
	endsequence

	a_div_write_lands: assert property (@(posedge i_clock) disable iff (!i_nrst)
		div_wr |=> o_baud_divisor_high == $past(i_reg_wdata)) else $error("divisor write not stored");
	a_div_gate_holds: assert property (@(posedge i_clock) disable iff (!i_nrst)
		!div_wr |=> $stable(o_baud_divisor_high)) else $error("divisor changed without open write");
	a_div_soft_keep: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(i_soft_reset && !div_wr) |=> $stable(o_baud_divisor_high)) else $error("soft reset touched divisor");
	a_id_mirror_top: assert property (@(posedge i_clock) disable iff (!i_nrst)
		id_rd |=> o_reg_rdata[7:6] == {2{$past(o_fifo_enable)}}) else $error("id top bits do not mirror enable");
	a_id_line_wins: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(id_rd && i_src_line_status) |=> o_reg_rdata[5:0] == 6'h06) else $error("line status not top priority");
	a_id_lowest_src: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(id_rd && i_src_flow_inactive && !i_src_line_status && !i_src_rx_timeout && !i_src_rx_data
		&& !i_src_tx_empty && !i_src_modem && !i_src_gpio_change && !i_src_xoff_special)
		|=> o_reg_rdata[5:0] == 6'h20) else $error("flow inactive code wrong");
	a_id_none_pending: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(id_rd && !i_src_line_status && !i_src_rx_timeout && !i_src_rx_data && !i_src_tx_empty
		&& !i_src_modem && !i_src_gpio_change && !i_src_xoff_special && !i_src_flow_inactive)
		|=> o_reg_rdata[0] && !o_int_pending) else $error("idle id bit not set");
	// Back-to-back reset writes legally stretch the pulse, so only a lone request must give a single cycle.
	a_txreset_once: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(fc_wr && i_reg_wdata[FC_TX_RESET_BIT]) ##1 !(fc_wr && i_reg_wdata[FC_TX_RESET_BIT]) |-> s_txreset_pulse)
		else $error("transmit reset pulse wrong");
	a_txreset_zero: assert property (@(posedge i_clock) disable iff (!i_nrst)
		!(fc_wr && i_reg_wdata[2]) |=> !o_tx_fifo_reset) else $error("spurious transmit reset");
	a_tx_trig_locked: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(fc_wr && !i_enhanced_feature_ctrl[4] && i_reg_wdata[0] && o_fifo_enable && !i_soft_reset)
		|=> ##1 $stable(o_tx_trigger_level)) else $error("transmit trigger changed while locked");
	a_rx_trig_level: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(fc_wr && i_reg_wdata[7:6] == 2'h2 && i_reg_wdata[0]) |=> ##1 o_rx_trigger_level == 7'h38)
		else $error("receive trigger 56 not applied");
	a_single_mode: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(fc_wr && !i_reg_wdata[0]) |=> ##1 (o_rx_trigger_level == 7'h01 && o_tx_trigger_level == 7'h01))
		else $error("single-character trigger not applied");

	// Each lower source is checked only while every source above it is quiet.
	a_id_timeout_code: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(id_rd && src_vec[6] && !src_vec[7]) |=> o_reg_rdata[5:0] == 6'h0C) else $error("timeout code wrong");
	a_id_rxdata_code: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(id_rd && src_vec[5] && src_vec[7:6] == 2'h0) |=> o_reg_rdata[5:0] == 6'h04)
		else $error("receive data code wrong");
	a_id_txempty_code: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(id_rd && src_vec[4] && src_vec[7:5] == 3'h0) |=> o_reg_rdata[5:0] == 6'h02)
		else $error("transmit empty code wrong");
	a_id_modem_code: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(id_rd && src_vec[3] && src_vec[7:4] == 4'h0) |=> o_reg_rdata[5:0] == 6'h00)
		else $error("modem code wrong");
	a_id_gpio_code: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(id_rd && src_vec[2] && src_vec[7:3] == 5'h00) |=> o_reg_rdata[5:0] == 6'h30)
		else $error("input pin change code wrong");
	a_id_xoff_code: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(id_rd && src_vec[1] && src_vec[7:2] == 6'h00) |=> o_reg_rdata[5:0] == 6'h10)
		else $error("xoff or special code wrong");
	a_id_read_matches: assert property (@(posedge i_clock) disable iff (!i_nrst)
		id_rd |=> o_reg_rdata == o_interrupt_source_id) else $error("id read differs from id register");
	a_pending_inverse: assert property (@(posedge i_clock) disable iff (!i_nrst)
		o_int_pending == !o_interrupt_source_id[0]) else $error("pending flag disagrees with id bit");

	// Enable and trigger fields move only through an open write or a software reset.
	a_fifo_en_write: assert property (@(posedge i_clock) disable iff (!i_nrst)
		fc_wr |=> o_fifo_enable == $past(i_reg_wdata[FC_FIFO_ENABLE_BIT])) else $error("fifo enable not stored");
	a_fc_gate_closed: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(!fc_wr && !i_soft_reset) |=> $stable(o_fifo_enable)) else $error("fifo enable changed without write");
	a_soft_clears: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_soft_reset |=> (!o_fifo_enable && !o_tx_fifo_reset)) else $error("software reset left fifo control");
	a_rx_trig_60: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(fc_wr && i_reg_wdata[7:6] == 2'h3 && i_reg_wdata[0]) |=> ##1 o_rx_trigger_level == 7'h3C)
		else $error("receive trigger 60 not applied");
	a_tx_trig_32: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(fc_wr && i_reg_wdata[5:4] == 2'h2 && i_reg_wdata[0] && i_enhanced_feature_ctrl[4])
		|=> ##1 o_tx_trigger_level == 7'h20) else $error("transmit trigger 32 not applied");

	// Read data is a register that only a read strobe may move.
	a_div_read_back: assert property (@(posedge i_clock) disable iff (!i_nrst)
		div_rd |=> o_reg_rdata == $past(o_baud_divisor_high)) else $error("divisor read data wrong");
	a_closed_read_zero: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(i_reg_read && !div_rd && !id_rd) |=> o_reg_rdata == READ_UNMAPPED) else $error("closed read not zero");
	a_rdata_holds: assert property (@(posedge i_clock) disable iff (!i_nrst)
		!i_reg_read |=> $stable(o_reg_rdata)) else $error("read data moved without read");
endmodule : uiifc_regs

// [bench/uiifc_host_model.sv]
// Host-side model of the register port: single-cycle write and read strobes.
`timescale 1ns/10ps
module uiifc_host_model (
	input wire logic i_clock,
	input wire logic [7:0] i_rdata,
	output logic [2:0] o_addr,
	output logic o_write,
	output logic o_read,
	output logic [7:0] o_wdata
);
	initial begin
		o_addr = 3'h0;
		o_write = 1'b0;
		o_read = 1'b0;
		o_wdata = 8'h00;
	end
	// Address and data are inverted once released so stale values are never mistaken for live ones.
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge i_clock);
		o_addr = a;
		o_wdata = d;
		o_write = 1'b1;
		@(posedge i_clock);
		@(negedge i_clock);
		o_write = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(negedge i_clock);
		o_addr = a;
		o_read = 1'b1;
		@(posedge i_clock);
		@(negedge i_clock);
		d = i_rdata;
		o_read = 1'b0;
		o_addr = ~a;
	endtask : rd
endmodule : uiifc_host_model

// [bench/tb_top.sv]
// Self-checking bench for the divisor, interrupt identification and FIFO control registers.
`timescale 1ns/10ps
module tb_top;
	import uiifc_pkg::*;
	logic i_clock = 1'b0, i_nrst = 1'b0, i_soft_reset = 1'b0, wr_s, rd_s;
	logic [2:0] addr;
	logic [7:0] wdata, lc = 8'h00, efc = 8'h00, src = 8'h00, rdata, div, iid, rv;
	logic pend, fen, txr;
	logic [LEVEL_W-1:0] rxl, txl;
	int n_fail = 0, checks_done = 0;
	initial begin
		forever #20 i_clock = ~i_clock;
	end
	uiifc_host_model host (.i_clock(i_clock), .i_rdata(rdata), .o_addr(addr), .o_write(wr_s), .o_read(rd_s),
		.o_wdata(wdata));
	uiifc_regs DUT (.i_clock(i_clock), .i_nrst(i_nrst), .i_soft_reset(i_soft_reset), .i_reg_addr(addr),
		.i_reg_write(wr_s), .i_reg_read(rd_s), .i_reg_wdata(wdata), .i_line_control(lc),
		.i_enhanced_feature_ctrl(efc), .i_src_line_status(src[7]), .i_src_rx_timeout(src[6]),
		.i_src_rx_data(src[5]), .i_src_tx_empty(src[4]), .i_src_modem(src[3]), .i_src_gpio_change(src[2]),
		.i_src_xoff_special(src[1]), .i_src_flow_inactive(src[0]), .o_reg_rdata(rdata),
		.o_baud_divisor_high(div), .o_interrupt_source_id(iid), .o_int_pending(pend), .o_fifo_enable(fen),
		.o_tx_fifo_reset(txr), .o_rx_trigger_level(rxl), .o_tx_trigger_level(txl));
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (e !== g) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	task automatic t_reset;
		chk("divisor", 8'h00, div);
		chk("id", 8'h01, iid);
		chk("pending", 8'h00, {7'h00, pend});
		chk("fifo enable", 8'h00, {7'h00, fen});
		chk("rx level", 8'h01, {1'b0, rxl});
		chk("tx level", 8'h01, {1'b0, txl});
		$display("test reset done");
	endtask : t_reset
	task automatic t_divisor;
		lc = 8'h80;
		host.wr(3'h1, 8'hA5);
		chk("divisor out", 8'hA5, div);
		host.rd(3'h1, rv);
		chk("divisor read", 8'hA5, rv);
		lc = 8'hBF;
		host.wr(3'h1, 8'h3C);
		host.rd(3'h1, rv);
		chk("divisor gated read", 8'h00, rv);
		lc = 8'h00;
		host.rd(3'h1, rv);
		chk("divisor closed read", 8'h00, rv);
		chk("divisor kept", 8'hA5, div);
		$display("test divisor done");
	endtask : t_divisor
	task automatic t_priority;
		logic [5:0] codes [8];
		codes = '{ID_LINE_STATUS, ID_RX_TIMEOUT, ID_RX_DATA, ID_TX_EMPTY, ID_MODEM, ID_GPIO_CHANGE,
			ID_XOFF_SPECIAL, ID_FLOW_INACTIVE};
		lc = 8'h00;
		// Each pass leaves every lower source pending too, so only the winner may show.
		for (int i = 0; i < 8; i++) begin
			src = 8'hFF >> i;
			host.rd(3'h2, rv);
			chk("id read", {2'b00, codes[i]}, rv);
			chk("id out", {2'b00, codes[i]}, iid);
			chk("pending", 8'h01, {7'h00, pend});
		end
		src = 8'h00;
		host.rd(3'h2, rv);
		chk("id idle", 8'h01, rv);
		$display("test priority done");
	endtask : t_priority
	task automatic t_fifo;
		logic [6:0] rxt [4], txt [4];
		rxt = '{7'h08, 7'h10, 7'h38, 7'h3C};
		txt = '{7'h08, 7'h10, 7'h20, 7'h38};
		lc = 8'h00;
		efc = 8'h10;
		for (int j = 0; j < 4; j++) begin
			host.wr(3'h2, {j[1:0], j[1:0], 4'h5});
			chk("tx reset pulse", 8'h01, {7'h00, txr});
			chk("fifo enable", 8'h01, {7'h00, fen});
			@(negedge i_clock);
			chk("tx reset end", 8'h00, {7'h00, txr});
			chk("rx level", {1'b0, rxt[j]}, {1'b0, rxl});
			chk("tx level", {1'b0, txt[j]}, {1'b0, txl});
		end
		host.rd(3'h2, rv);
		chk("id mirror", 8'hC1, rv);
		efc = 8'h00;
		host.wr(3'h2, 8'h01);
		chk("no tx reset", 8'h00, {7'h00, txr});
		@(negedge i_clock);
		chk("rx level", 8'h08, {1'b0, rxl});
		chk("tx level locked", 8'h38, {1'b0, txl});
		lc = 8'h80;
		host.wr(3'h2, 8'hC4);
		chk("gated tx reset", 8'h00, {7'h00, txr});
		@(negedge i_clock);
		chk("gated rx level", 8'h08, {1'b0, rxl});
		host.rd(3'h5, rv);
		chk("unmapped read", 8'h00, rv);
		$display("test fifo done");
	endtask : t_fifo
	task automatic t_soft;
		@(negedge i_clock);
		i_soft_reset = 1'b1;
		@(negedge i_clock);
		i_soft_reset = 1'b0;
		chk("soft fifo enable", 8'h00, {7'h00, fen});
		@(negedge i_clock);
		chk("soft rx level", 8'h01, {1'b0, rxl});
		chk("soft tx level", 8'h01, {1'b0, txl});
		chk("soft divisor", 8'hA5, div);
		lc = 8'h00;
		host.rd(3'h2, rv);
		chk("soft id", 8'h01, rv);
		host.wr(3'h2, 8'h01);
		@(negedge i_clock);
		chk("reenable rx level", 8'h08, {1'b0, rxl});
		host.wr(3'h2, 8'hC4);
		chk("disable fifo", 8'h00, {7'h00, fen});
		chk("disabled tx reset", 8'h01, {7'h00, txr});
		@(negedge i_clock);
		chk("single rx level", 8'h01, {1'b0, rxl});
		chk("single tx level", 8'h01, {1'b0, txl});
		$display("test soft reset done");
	endtask : t_soft
	task automatic t_power;
		host.wr(3'h2, 8'h01);
		@(negedge i_clock);
		i_nrst = 1'b0;
		@(negedge i_clock);
		chk("por divisor", 8'h00, div);
		chk("por id", 8'h01, iid);
		chk("por fifo enable", 8'h00, {7'h00, fen});
		i_nrst = 1'b1;
		@(negedge i_clock);
		chk("por id after", 8'h01, iid);
		chk("por rx level", 8'h01, {1'b0, rxl});
		$display("test power reset done");
	endtask : t_power
	initial begin
		repeat (20000) @(posedge i_clock);
		n_fail++;
		end_sim();
	end
	initial begin
		repeat (12) @(posedge i_clock);
		@(negedge i_clock);
		i_nrst = 1'b1;
		@(negedge i_clock);
		t_reset();
		t_divisor();
		t_priority();
		t_fifo();
		t_soft();
		t_power();
		end_sim();
	end
endmodule : tb_top
